// [rtl/irq_arbiter.v]
// fixed-order priority encoder with registered winner
`timescale 1ns/1ps
`include "irq_handler_defines.vh"
module irq_arbiter
(
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire [21:0] req_i,
  output reg         any_o,
  output reg  [4:0]  slot_o
);
  // ********************************
  // lowest order number wins
  // ********************************
  function [5:0] pick;
    input [21:0] r;
    integer k;
    begin
      pick = 6'h00;
      for (k = `SLOT_COUNT - 1; k >= 0; k = k - 1)
        if (r[k])
          pick = {1'b1, k[4:0]};
    end
  endfunction

  wire [5:0] win = pick(req_i);

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      any_o  <= 1'b0;
      slot_o <= 5'h00;
    end
    else
    begin
      any_o  <= win[5];
      slot_o <= win[4:0];
    end
  end
endmodule

// [rtl/irq_handler_defines.vh]
// constants for the vectored interrupt handler
`ifndef IRQ_HANDLER_DEFINES_VH
`define IRQ_HANDLER_DEFINES_VH
`define SLOT_COUNT        22
`define UNUSED_SLOT       20
`define RESET_VECTOR      16'h0000
`define VECTOR_BASE       16'h0003
`define VECTOR_STEP       16'h0008
`define GLOBAL_EN_BIT     7
`define TIMER_CONTROL_REG_TRIG0_BIT    0
`define TIMER_CONTROL_REG_PEND0_BIT    1
`define TIMER_CONTROL_REG_TRIG1_BIT    2
`define TIMER_CONTROL_REG_PEND1_BIT    3
`define P1_FIRST_BIT      4
`define P1_LAST_BIT       7
`define EXTENDED_ENABLE_REG_2_RSVD_BIT     6
`define SLOT_EXT0         0
`define SLOT_EXT1         2
`define SLOT_UART         4
`define SLOT_EXT4         16
`define CALL_CYCLES       4
`define REG_RESET         8'h00
`endif

// [rtl/vectored_interrupt_handler.v]
// vectored interrupt handler: flags, masks, two-level arbitration
`timescale 1ns/1ps
`include "irq_handler_defines.vh"
// Operation
// - twenty-two source slots, each on one of two priority levels
// - valid event sets pending flag regardless of any enable
// - enabled pending source raises a call request after current instruction
// - each routine ends with return; core resumes interrupted flow
// - disabled source with flag set raises nothing
// - global enable bit 7 gates every per-source enable
// - enable bits in primary, extended 1 and extended 2 registers
// - some flags clear on vectoring; software clears the rest
// - flag still set after return re-requests after one instruction
// - software write of one to a flag acts like real event; FLAG_SET_I sets only the rx flag of slot 4, never tx
// - lines 0 and 1 select low level or falling edge
// - line 0 and 1 flags at timer control bits 1 and 3
// - edge-mode line 0/1 flag clears when core vectors to it
// - level-mode line 0/1 flag follows the pin, no latching
// - lines 4 to 7 falling edge only, flags at port1 bits 4-7
// - reset vector zero; slot n vectors to 0x0003 plus 8n
// - slot 20 unused, no flag, enable bit reserved
// - multi-flag source requests whenever any of its flags set
// - high pre-empts low routine; high routine never pre-empted
// - priority level of each source comes from PRIORITY_HIGH_I; reset does not clear it
// - high level first, then lower order number wins
// - requests sampled every cycle; response at least five cycles
// - equal or higher running routine blocks until return plus one
module vectored_interrupt_handler
(
  input  wire        CLK_SYS_I,
  input  wire        RESET_I,
  input  wire        EXT_IRQ_LINE_0_I,
  input  wire        EXT_IRQ_LINE_1_I,
  input  wire [7:4]  EXT_IRQ_LINE_HI_I,
  input  wire [21:0] PERIPH_EVENT_I,
  input  wire        SERIAL_RX_EVENT_I,
  input  wire        SERIAL_TX_EVENT_I,
  input  wire [7:0]  PRIMARY_IRQ_ENABLE_REG_I,
  input  wire [7:0]  EXTENDED_ENABLE_REG_1_I,
  input  wire [7:0]  EXTENDED_ENABLE_REG_2_I,
  input  wire [21:0] PRIORITY_HIGH_I,
  input  wire        EXT0_TRIGGER_SELECT_I,
  input  wire        EXT1_TRIGGER_SELECT_I,
  input  wire [21:0] FLAG_SET_I,
  input  wire [21:0] FLAG_CLEAR_I,
  input  wire        SERIAL_RX_CLEAR_I,
  input  wire        SERIAL_TX_CLEAR_I,
  input  wire        INSTR_DONE_I,
  input  wire        CALL_TAKEN_I,
  input  wire        RETURN_FROM_IRQ_I,
  output reg  [21:0] PENDING_O,
  output reg  [7:0]  TIMER_CONTROL_REG_O,
  output reg  [7:0]  PORT1_IRQ_FLAG_REG_O,
  output reg         SERIAL_RX_PENDING_O,
  output reg         SERIAL_TX_PENDING_O,
  output reg         CALL_REQ_O,
  output reg  [15:0] CALL_VECTOR_O,
  output reg  [1:0]  IN_SERVICE_O
);
  // ********************************
  // pin synchronisers and edge detect
  // ********************************
  reg  [5:0]  pin_s1_q;
  reg  [5:0]  pin_s2_q;
  reg  [5:0]  pin_s3_q;
  wire [5:0]  pins = {EXT_IRQ_LINE_HI_I, EXT_IRQ_LINE_1_I, EXT_IRQ_LINE_0_I};
  wire [5:0]  fall = pin_s3_q & ~pin_s2_q;

  always @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      pin_s1_q <= 6'h3f;
      pin_s2_q <= 6'h3f;
      pin_s3_q <= 6'h3f;
    end
    else
    begin
      pin_s1_q <= pins;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // ********************************
  // enables and pending flags
  // ********************************
  wire [21:0] src_en;
  assign src_en[5:0]   = PRIMARY_IRQ_ENABLE_REG_I[5:0];
  assign src_en[13:6]  = EXTENDED_ENABLE_REG_1_I;
  assign src_en[19:14] = EXTENDED_ENABLE_REG_2_I[5:0];
  assign src_en[20]    = 1'b0;
  assign src_en[21]    = EXTENDED_ENABLE_REG_2_I[7];
  wire global_en = PRIMARY_IRQ_ENABLE_REG_I[`GLOBAL_EN_BIT];

  reg  [21:0] flag_q;
  reg  [21:0] flag_d;
  reg         rx_q;
  reg         tx_q;
  reg  [21:0] event_v;
  reg  [21:0] vec_clr;
  wire [21:0] pend_view;
  reg  [1:0]  in_svc_q;
  reg  [1:0]  state_q;
  reg  [4:0]  slot_q;
  reg  [2:0]  cnt_q;

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_CALL = 2'b01;
  localparam [1:0] ST_HOLD = 2'b10;

  // vector-time clear of the two edge-mode lines only
  always @*
  begin
    vec_clr = 22'h000000;
    if (CALL_TAKEN_I && state_q == ST_CALL)
    begin
      if (slot_q == `SLOT_EXT0 && EXT0_TRIGGER_SELECT_I)
        vec_clr[`SLOT_EXT0] = 1'b1;
      if (slot_q == `SLOT_EXT1 && EXT1_TRIGGER_SELECT_I)
        vec_clr[`SLOT_EXT1] = 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `SLOT_COUNT; g = g + 1)
    begin : gen_flag
      always @*
      begin
        if (g == `SLOT_EXT0)
          event_v[g] = EXT0_TRIGGER_SELECT_I ? fall[0] : 1'b0;
        else if (g == `SLOT_EXT1)
          event_v[g] = EXT1_TRIGGER_SELECT_I ? fall[1] : 1'b0;
        else if (g >= `SLOT_EXT4 && g < `SLOT_EXT4 + 4)
          // masked index stays in range for every slot
          event_v[g] = fall[((g - `SLOT_EXT4) & 3) + 2];
        else
          event_v[g] = PERIPH_EVENT_I[g];
        // set beats clear; software set behaves as an event
        if (g == `UNUSED_SLOT)
          flag_d[g] = 1'b0;
        else if (event_v[g] || FLAG_SET_I[g])
          flag_d[g] = 1'b1;
        else if (FLAG_CLEAR_I[g] || vec_clr[g])
          flag_d[g] = 1'b0;
        else
          flag_d[g] = flag_q[g];
      end
    end
  endgenerate

  // level mode: flag is the inverted synchronised pin itself
  assign pend_view[`SLOT_EXT0] = EXT0_TRIGGER_SELECT_I ?
    flag_q[`SLOT_EXT0] : ~pin_s2_q[0];
  assign pend_view[`SLOT_EXT1] = EXT1_TRIGGER_SELECT_I ?
    flag_q[`SLOT_EXT1] : ~pin_s2_q[1];
  assign pend_view[1] = flag_q[1];
  assign pend_view[3] = flag_q[3];
  assign pend_view[`SLOT_UART] = rx_q | tx_q;
  assign pend_view[21:5] = flag_q[21:5];

  always @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      flag_q <= 22'h000000;
      rx_q   <= 1'b0;
      tx_q   <= 1'b0;
    end
    else
    begin
      flag_q <= flag_d;
      if (SERIAL_RX_EVENT_I || FLAG_SET_I[`SLOT_UART])
        rx_q <= 1'b1;
      else if (SERIAL_RX_CLEAR_I)
        rx_q <= 1'b0;
      if (SERIAL_TX_EVENT_I)
        tx_q <= 1'b1;
      else if (SERIAL_TX_CLEAR_I)
        tx_q <= 1'b0;
    end
  end

  // ********************************
  // two-level arbitration
  // ********************************
  wire [21:0] active = pend_view & src_en & {22{global_en}};
  // a level is eligible only above every routine in service
  wire        hi_ok  = ~in_svc_q[1];
  wire        lo_ok  = ~in_svc_q[1] & ~in_svc_q[0];
  wire [21:0] hi_req = active & PRIORITY_HIGH_I & {22{hi_ok}};
  wire [21:0] lo_req = active & ~PRIORITY_HIGH_I & {22{lo_ok}};
  wire        hi_any;
  wire [4:0]  hi_slot;
  wire        lo_any;
  wire [4:0]  lo_slot;
  reg         hi_win_q;

  irq_arbiter u_hi_arb
  (
    .clk_i   (CLK_SYS_I),
    .reset_i (RESET_I),
    .req_i   (hi_req),
    .any_o   (hi_any),
    .slot_o  (hi_slot)
  );

  irq_arbiter u_lo_arb
  (
    .clk_i   (CLK_SYS_I),
    .reset_i (RESET_I),
    .req_i   (lo_req),
    .any_o   (lo_any),
    .slot_o  (lo_slot)
  );

  // ********************************
  // call sequencing and in-service
  // ********************************
  // sampled winner is one cycle old, giving the detection cycle
  always @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      state_q       <= ST_IDLE;
      slot_q        <= 5'h00;
      hi_win_q      <= 1'b0;
      cnt_q         <= 3'h0;
      in_svc_q      <= 2'b00;
      CALL_REQ_O    <= 1'b0;
      CALL_VECTOR_O <= `RESET_VECTOR;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          // after a return one instruction must complete first
          if (INSTR_DONE_I && (hi_any || lo_any))
          begin
            state_q       <= ST_CALL;
            slot_q        <= hi_any ? hi_slot : lo_slot;
            hi_win_q      <= hi_any;
            CALL_REQ_O    <= 1'b1;
            CALL_VECTOR_O <= `VECTOR_BASE + `VECTOR_STEP *
              {11'h000, (hi_any ? hi_slot : lo_slot)};
          end
        end
        ST_CALL:
        begin
          if (CALL_TAKEN_I)
          begin
            CALL_REQ_O <= 1'b0;
            if (hi_win_q)
              in_svc_q[1] <= 1'b1;
            else
              in_svc_q[0] <= 1'b1;
            cnt_q   <= 3'h0;
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          // long call occupies the core; no new decision meanwhile
          if (cnt_q == `CALL_CYCLES - 2)
            state_q <= ST_IDLE;
          else
            cnt_q <= cnt_q + 3'h1;
        end
        default:
          state_q <= ST_IDLE;
      endcase
      if (RETURN_FROM_IRQ_I && state_q != ST_CALL)
      begin
        if (in_svc_q[1])
          in_svc_q[1] <= 1'b0;
        else
          in_svc_q[0] <= 1'b0;
      end
    end
  end

  // ********************************
  // registered flag views
  // ********************************
  always @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      PENDING_O            <= 22'h000000;
      TIMER_CONTROL_REG_O  <= `REG_RESET;
      PORT1_IRQ_FLAG_REG_O <= `REG_RESET;
      SERIAL_RX_PENDING_O  <= 1'b0;
      SERIAL_TX_PENDING_O  <= 1'b0;
      IN_SERVICE_O         <= 2'b00;
    end
    else
    begin
      PENDING_O <= pend_view;
      TIMER_CONTROL_REG_O <= {4'h0, pend_view[`SLOT_EXT1],
        EXT1_TRIGGER_SELECT_I, pend_view[`SLOT_EXT0],
        EXT0_TRIGGER_SELECT_I};
      PORT1_IRQ_FLAG_REG_O <= {pend_view[`SLOT_EXT4 + 3:`SLOT_EXT4],
        4'h0};
      SERIAL_RX_PENDING_O <= rx_q;
      SERIAL_TX_PENDING_O <= tx_q;
      IN_SERVICE_O        <= in_svc_q;
    end
  end
endmodule

// [test/core_model.sv]
// core model: instruction boundaries, long call and return
`timescale 1ns/1ps
module core_model
(
  input  wire clk_i,
  input  wire reset_i,
  input  wire call_req_i,
  input  wire ret_cmd_i,
  output reg  instr_done_o,
  output reg  call_taken_o,
  output reg  ret_o
);
  reg [1:0] cnt_q;
  reg       ph_q;
  always @(posedge clk_i)
  begin
    instr_done_o <= 1'b0;
    call_taken_o <= 1'b0;
    ret_o        <= 1'b0;
    if (reset_i)
    begin
      cnt_q <= 2'h0;
      ph_q  <= 1'b0;
    end
    else if (call_req_i && !call_taken_o)
    begin
      // long call spends four cycles
      cnt_q        <= cnt_q + 2'h1;
      call_taken_o <= (cnt_q == 2'h3);
    end
    else if (ret_cmd_i)
      ret_o <= 1'b1;
    else
    begin
      // two-cycle instructions between boundaries
      ph_q         <= !ph_q;
      instr_done_o <= ph_q;
    end
  end
endmodule

// [test/vectored_interrupt_handler_tb.sv]
// self-checking bench for the vectored interrupt handler
`timescale 1ns/1ps
module vectored_interrupt_handler_tb;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         p0 = 1'b1;
  reg  [7:4]  phi = 4'hf;
  reg  [7:0]  en0 = 8'h00;
  reg  [7:0]  en1 = 8'hff;
  reg  [7:0]  en2 = 8'hbf;
  reg  [21:0] prio = 22'h0;
  reg         t0 = 1'b1;
  reg  [21:0] fset = 22'h0;
  reg  [21:0] fclr = 22'h0;
  reg         rret = 1'b0;
  reg         p1 = 1'b1;
  reg  [21:0] pev = 22'h0;
  reg         txe = 1'b0;
  wire        tx;
  wire        done;
  wire        taken;
  wire        retd;
  wire        creq;
  wire        rx;
  wire [15:0] cvec;
  wire [21:0] pend;
  wire [7:0]  timer_control_reg;
  wire [7:0]  p1f;
  wire [1:0]  is;
  integer     err_count;
  integer     n_checks;
  integer     cyc = 0;
  integer     s;
  always #5 clk = !clk;
  vectored_interrupt_handler vectored_interrupt_handler_i (
    .CLK_SYS_I(clk), .RESET_I(rst), .EXT_IRQ_LINE_0_I(p0),
    .EXT_IRQ_LINE_1_I(p1), .EXT_IRQ_LINE_HI_I(phi),
    .PERIPH_EVENT_I(pev), .SERIAL_RX_EVENT_I(1'b0),
    .SERIAL_TX_EVENT_I(txe), .PRIMARY_IRQ_ENABLE_REG_I(en0),
    .EXTENDED_ENABLE_REG_1_I(en1), .EXTENDED_ENABLE_REG_2_I(en2),
    .PRIORITY_HIGH_I(prio), .EXT0_TRIGGER_SELECT_I(t0),
    .EXT1_TRIGGER_SELECT_I(t0), .FLAG_SET_I(fset), .FLAG_CLEAR_I(fclr),
    .SERIAL_RX_CLEAR_I(fclr[4]), .SERIAL_TX_CLEAR_I(fclr[4]),
    .INSTR_DONE_I(done), .CALL_TAKEN_I(taken), .RETURN_FROM_IRQ_I(retd),
    .PENDING_O(pend), .TIMER_CONTROL_REG_O(timer_control_reg),
    .PORT1_IRQ_FLAG_REG_O(p1f), .SERIAL_RX_PENDING_O(rx),
    .SERIAL_TX_PENDING_O(tx), .CALL_REQ_O(creq), .CALL_VECTOR_O(cvec),
    .IN_SERVICE_O(is));
  core_model core_model_i (.clk_i(clk), .reset_i(rst), .call_req_i(creq),
    .ret_cmd_i(rret), .instr_done_o(done), .call_taken_o(taken),
    .ret_o(retd));
  // ****************************************
  // helpers
  // ****************************************
  task report_and_stop;
    begin
      if (err_count == 0 && n_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
        err_count = err_count + 1;
        $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
      end
    end
  endtask
  task step(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task pulse(input integer k);
    begin
      fset[k] = 1'b1;
      step(1);
      fset = 22'h0;
      // idle cycle keeps back-to-back pulses apart
      step(1);
    end
  endtask
  task call_is(input [15:0] exp);
    integer k;
    begin
      k = 0;
      while (taken !== 1'b1 && k < 60)
      begin
        step(1);
        k = k + 1;
      end
      chk(k < 60 ? cvec : 16'hffff, exp);
      step(1);
    end
  endtask
  // cores with a blocked request must see no call within 30 cycles
  task none;
    integer hit;
    begin
      hit = 0;
      repeat (30)
      begin
        step(1);
        hit = hit | taken;
      end
      chk(hit, 0);
    end
  endtask
  // software clears its flags, then returns
  task fin(input [21:0] m);
    begin
      fclr = m;
      step(1);
      fclr = 22'h0;
      rret = 1'b1;
      step(1);
      rret = 1'b0;
      step(2);
    end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      err_count = err_count + 1;
      report_and_stop;
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    err_count = 0;
    n_checks = 0;
    step(16);
    rst = 1'b0;
    step(2);
    chk(cvec, 16'h0000);
    chk(is, 0);
    pev[1] = 1'b1;
    step(1);
    pev = 22'h0;
    step(1);
    chk(pend[1], 1);
    none();
    en0 = 8'h80;
    none();
    en0 = 8'hbf;
    call_is(16'h000b);
    fin(22'h2);
    for (s = 0; s < 22; s = s + 1)
    begin
      pulse(s);
      if (s == 20)
        none();
      else
      begin
        call_is(16'h0003 + 8 * s);
        if (s == 4)
          chk(rx, 1);
        fin(22'h1 << s);
      end
    end
    txe = 1'b1;
    step(1);
    txe = 1'b0;
    call_is(16'h0023);
    chk(tx, 1);
    fin(22'h1 << 4);
    chk(tx, 0);
    pulse(3);
    call_is(16'h001b);
    fin(22'h0);
    call_is(16'h001b);
    fin(22'h8);
    en0 = 8'h3f;
    prio[9] = 1'b1;
    pulse(6);
    pulse(7);
    pulse(9);
    en0 = 8'hbf;
    call_is(16'h004b);
    pulse(12);
    none();
    fin(22'h1 << 9);
    call_is(16'h0033);
    prio[13] = 1'b1;
    prio[14] = 1'b1;
    pulse(13);
    call_is(16'h006b);
    pulse(14);
    chk(is, 2'h3);
    none();
    fin(22'h1 << 13);
    call_is(16'h0073);
    fin(22'h1 << 14);
    none();
    fin(22'h1 << 6);
    call_is(16'h003b);
    fin(22'h1 << 7);
    call_is(16'h0063);
    fin(22'h1 << 12);
    p0 = 1'b0;
    call_is(16'h0003);
    step(1);
    chk(timer_control_reg[1], 0);
    p0 = 1'b1;
    fin(22'h0);
    p1 = 1'b0;
    call_is(16'h0013);
    step(1);
    chk(timer_control_reg[3], 0);
    p1 = 1'b1;
    fin(22'h0);
    t0 = 1'b0;
    p0 = 1'b0;
    step(5);
    chk(timer_control_reg, 8'h02);
    call_is(16'h0003);
    p0 = 1'b1;
    step(6);
    chk(timer_control_reg[1], 0);
    fin(22'h0);
    phi[4] = 1'b0;
    call_is(16'h0083);
    chk(p1f, 8'h10);
    phi = 4'hf;
    fin(22'h1 << 16);
    report_and_stop;
  end
endmodule

// [test/vih_monitor.sv]
// assertion checker for the vectored interrupt handler
`timescale 1ns/1ps
module vih_monitor
(
  input wire        CLK_SYS_I,
  input wire        RESET_I,
  input wire        EXT_IRQ_LINE_0_I,
  input wire [7:0]  PRIMARY_IRQ_ENABLE_REG_I,
  input wire [21:0] PRIORITY_HIGH_I,
  input wire        EXT0_TRIGGER_SELECT_I,
  input wire        INSTR_DONE_I,
  input wire        CALL_TAKEN_I,
  input wire [7:0]  TIMER_CONTROL_REG_O,
  input wire        CALL_REQ_O,
  input wire [15:0] CALL_VECTOR_O,
  input wire [1:0]  IN_SERVICE_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RESET_I);
  sequence s_off;
    !PRIMARY_IRQ_ENABLE_REG_I[7] [*3];
  endsequence
  sequence s_lvl;
    (!EXT0_TRIGGER_SELECT_I && $stable(EXT_IRQ_LINE_0_I)) [*6];
  endsequence
  property p_vec;
    CALL_REQ_O |-> CALL_VECTOR_O[2:0] == 3'h3 && CALL_VECTOR_O <= 16'h00ab
      && CALL_VECTOR_O != 16'h00a3;
  endproperty
  property p_hold;
    CALL_REQ_O && !CALL_TAKEN_I |=> CALL_REQ_O && $stable(CALL_VECTOR_O);
  endproperty
  property p_take;
    CALL_TAKEN_I && CALL_REQ_O |=> !CALL_REQ_O ##[0:1] IN_SERVICE_O != 2'h0;
  endproperty
  property p_gate;
    s_off ##0 !CALL_REQ_O |=> !CALL_REQ_O;
  endproperty
  property p_lvl;
    s_lvl |-> TIMER_CONTROL_REG_O[1] == !EXT_IRQ_LINE_0_I;
  endproperty
  property p_hipre;
    $rose(CALL_REQ_O) |-> !$past(IN_SERVICE_O[1]);
  endproperty
  property p_lopre;
    $rose(CALL_REQ_O) && $past(IN_SERVICE_O[0])
      |-> PRIORITY_HIGH_I[(CALL_VECTOR_O - 16'h0003) >> 3];
  endproperty
  property p_bound;
    $rose(CALL_REQ_O) |-> $past(INSTR_DONE_I);
  endproperty
  property p_edge;
    CALL_TAKEN_I && CALL_REQ_O && CALL_VECTOR_O == 16'h0003
      && EXT0_TRIGGER_SELECT_I |-> ##[1:2] !TIMER_CONTROL_REG_O[1];
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  a_hold: assert property (p_hold) else $error("request dropped");
  a_take: assert property (p_take) else $error("no in-service");
  a_gate: assert property (p_gate) else $error("global off");
  a_lvl: assert property (p_lvl) else $error("level flag");
  a_hipre: assert property (p_hipre) else $error("high pre-empted");
  a_lopre: assert property (p_lopre) else $error("low pre-empt");
  a_bound: assert property (p_bound) else $error("mid instr");
  a_edge: assert property (p_edge) else $error("edge flag kept");
endmodule
bind vectored_interrupt_handler vih_monitor vih_monitor_i (
  .CLK_SYS_I                (CLK_SYS_I),
  .RESET_I                  (RESET_I),
  .EXT_IRQ_LINE_0_I         (EXT_IRQ_LINE_0_I),
  .PRIMARY_IRQ_ENABLE_REG_I (PRIMARY_IRQ_ENABLE_REG_I),
  .PRIORITY_HIGH_I          (PRIORITY_HIGH_I),
  .EXT0_TRIGGER_SELECT_I    (EXT0_TRIGGER_SELECT_I),
  .INSTR_DONE_I             (INSTR_DONE_I),
  .CALL_TAKEN_I             (CALL_TAKEN_I),
  .TIMER_CONTROL_REG_O      (TIMER_CONTROL_REG_O),
  .CALL_REQ_O               (CALL_REQ_O),
  .CALL_VECTOR_O            (CALL_VECTOR_O),
  .IN_SERVICE_O             (IN_SERVICE_O)
);
